//--- pkg/pdca_map.svh
`ifndef PDCA_MAP_SVH
`define PDCA_MAP_SVH
// ==========================================================
// channel indices, lowest priority first
`define PDCA_CH_TWZ_TX 4'h0
`define PDCA_CH_UART_TX 4'h1
`define PDCA_CH_USART_TX 4'h2
`define PDCA_CH_DAC_TX 4'h3
`define PDCA_CH_SPI_TX 4'h4
`define PDCA_CH_TWZ_RX 4'h5
`define PDCA_CH_UART_RX 4'h6
`define PDCA_CH_USART_RX 4'h7
`define PDCA_CH_ADC_RX 4'h8
`define PDCA_CH_SPI_RX 4'h9
`define PDCA_NUM_CH 10
`define PDCA_FIRST_RX 5
// ==========================================================
// bus occupancy in master clock cycles
`define PDCA_CYC_TX 2'h1
`define PDCA_CYC_RX 2'h2
// ==========================================================
// address windows reachable by the engine
`define PDCA_SRAM_BASE 32'h20000000
`define PDCA_SRAM_MASK 32'hFF000000
`define PDCA_ROM_BASE 32'h00800000
`define PDCA_ROM_MASK 32'hFFF00000
`define PDCA_BRIDGE_BASE 32'h40000000
`define PDCA_BRIDGE_MASK 32'hF0000000
`endif

//--- pkg/pdca_pkg.sv
package pdca_pkg;
  // ========================================================
  // engine state
  typedef enum logic [1:0] {
    PDCA_IDLE = 2'b00,
    PDCA_READ = 2'b01,
    PDCA_WRITE = 2'b10
  } pdca_state_type;
  // bus direction of one beat
  typedef enum logic {
    PDCA_DIR_RD = 1'b0,
    PDCA_DIR_WR = 1'b1
  } pdca_dir_type;
endpackage : pdca_pkg

//--- verilog/pdca_buf2.sv
`timescale 1ns/1ps
// two-entry buffer: a stall by the receiver loses no word
module pdca_buf2 (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [31:0] in_data,
  input wire logic [3:0] in_ch,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [31:0] out_data,
  output logic [3:0] out_ch
);
  logic [31:0] data_q [0:1]; // storage
  logic [3:0] ch_q [0:1];
  logic rd_q; // read index
  logic wr_q; // write index
  logic [1:0] cnt_q; // fill level
  logic push;
  logic pop;

  // ========================================================
  // handshakes
  assign in_ready = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = data_q[rd_q];
  assign out_ch = ch_q[rd_q];

  // storage write
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      data_q[0] <= 32'h0;
      data_q[1] <= 32'h0;
      ch_q[0] <= 4'h0;
      ch_q[1] <= 4'h0;
    end else if (push) begin
      data_q[wr_q] <= in_data;
      ch_q[wr_q] <= in_ch;
    end
  end

  // pointers and level
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) wr_q <= ~wr_q;
      if (pop) rd_q <= ~rd_q;
      if (push && !pop) cnt_q <= cnt_q + 2'h1;
      else if (pop && !push) cnt_q <= cnt_q - 2'h1;
    end
  end

  AST_BUF_NO_OVER: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cnt_q <= 2'h2) else $error("buffer level above two");
  // a stalled head word must stand untouched until the sink takes it
  AST_BUF_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
    out_valid && !out_ready |=> out_valid && $stable(out_data)) else $error("stalled word lost");
endmodule : pdca_buf2

//--- verilog/pdca_engine.sv
`timescale 1ns/1ps
`include "pdca_map.svh"
module pdca_engine #(
  parameter bit HAS_DAC = 1'b1 // zero models the 48-pin variant
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // peripheral requests, one bit per channel
  input wire logic [9:0] ch_req,
  output logic [9:0] ch_ack,
  // per-channel peripheral holding register
  input wire logic [319:0] ch_rx_data,
  // buffer programming from the processor side
  input wire logic cfg_we,
  input wire logic [3:0] cfg_ch,
  input wire logic cfg_next,
  input wire logic [31:0] cfg_addr,
  input wire logic [15:0] cfg_count,
  // channel status
  output logic [9:0] ch_busy,
  output logic [9:0] ch_end,
  // system bus master
  output logic bus_req,
  output logic bus_write,
  output logic [31:0] bus_addr,
  output logic [31:0] bus_wdata,
  input wire logic [31:0] bus_rdata,
  output logic bus_err,
  // transmit data toward peripherals
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [31:0] tx_data,
  output logic [3:0] tx_ch
);
  // ========================================================
  // reset release
  logic rst_s1_q;
  logic rst_s2_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  logic rst_core_n;
  assign rst_core_n = rst_s2_q;

  // ========================================================
  // helpers
  // highest set bit wins; channel index is priority
  function automatic logic [3:0] pick_top(input logic [9:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < `PDCA_NUM_CH; i++) begin
      if (v[i]) r = 4'(i);
    end
    return r;
  endfunction : pick_top
  // flash is not wired for this master
  function automatic logic addr_ok(input logic [31:0] a);
    return ((a & `PDCA_SRAM_MASK) == `PDCA_SRAM_BASE) ||
      ((a & `PDCA_ROM_MASK) == `PDCA_ROM_BASE) ||
      ((a & `PDCA_BRIDGE_MASK) == `PDCA_BRIDGE_BASE);
  endfunction : addr_ok

  // ========================================================
  // channel pointer storage, current and next
  logic [31:0] cur_addr_q [0:9];
  logic [15:0] cur_cnt_q [0:9];
  logic [31:0] nxt_addr_q [0:9];
  logic [15:0] nxt_cnt_q [0:9];
  logic [9:0] present; // channels that exist
  logic [9:0] eligible; // requesting with work left
  logic [9:0] ch_end_q;
  logic [9:0] ack_q;
  assign present = HAS_DAC ? 10'h3FF : 10'h3F7;
  always_comb begin
    for (int i = 0; i < `PDCA_NUM_CH; i++) begin
      ch_busy[i] = cur_cnt_q[i] != 16'h0;
    end
  end
  assign eligible = ch_req & present & ch_busy;

  // ========================================================
  // beat engine
  pdca_pkg::pdca_state_type state_q;
  logic [3:0] gnt_q; // channel being served
  logic [31:0] addr_q; // memory address of beat
  logic beat_done; // beat retires this cycle
  logic buf_ready;
  logic [9:0] rx_mask;
  assign rx_mask = 10'h3E0;

  // arbitration and bus sequencing
  always_ff @(posedge clk_sys or negedge rst_core_n) begin
    if (!rst_core_n) begin
      state_q <= pdca_pkg::PDCA_IDLE;
      gnt_q <= 4'h0;
      addr_q <= 32'h0;
    end else begin
      case (state_q)
        pdca_pkg::PDCA_IDLE: begin
          if (|eligible && buf_ready) begin
            gnt_q <= pick_top(eligible);
            addr_q <= cur_addr_q[pick_top(eligible)];
            state_q <= pdca_pkg::PDCA_READ;
          end
        end
        pdca_pkg::PDCA_READ: begin
          // receive needs a second cycle to write memory
          if (rx_mask[gnt_q]) state_q <= pdca_pkg::PDCA_WRITE;
          else state_q <= pdca_pkg::PDCA_IDLE;
        end
        pdca_pkg::PDCA_WRITE: state_q <= pdca_pkg::PDCA_IDLE;
        default: state_q <= pdca_pkg::PDCA_IDLE;
      endcase
    end
  end

  assign beat_done = (state_q == pdca_pkg::PDCA_READ && !rx_mask[gnt_q]) ||
    (state_q == pdca_pkg::PDCA_WRITE);

  // bus drive: transmit reads memory, receive reads peripheral then writes
  always_comb begin
    bus_req = (state_q != pdca_pkg::PDCA_IDLE) && addr_ok(addr_q);
    bus_write = (state_q == pdca_pkg::PDCA_WRITE);
    bus_addr = addr_q;
    bus_wdata = ch_rx_data[gnt_q*32 +: 32];
    bus_err = (state_q != pdca_pkg::PDCA_IDLE) && !addr_ok(addr_q);
  end

  // ========================================================
  // pointer update and chaining
  always_ff @(posedge clk_sys or negedge rst_core_n) begin
    if (!rst_core_n) begin
      for (int i = 0; i < `PDCA_NUM_CH; i++) begin
        cur_addr_q[i] <= 32'h0;
        cur_cnt_q[i] <= 16'h0;
        nxt_addr_q[i] <= 32'h0;
        nxt_cnt_q[i] <= 16'h0;
      end
      ch_end_q <= 10'h0;
    end else begin
      ch_end_q <= 10'h0;
      if (beat_done) begin
        if (cur_cnt_q[gnt_q] == 16'h1 && nxt_cnt_q[gnt_q] != 16'h0) begin
          cur_addr_q[gnt_q] <= nxt_addr_q[gnt_q];
          cur_cnt_q[gnt_q] <= nxt_cnt_q[gnt_q];
          nxt_cnt_q[gnt_q] <= 16'h0;
        end else begin
          cur_addr_q[gnt_q] <= addr_q + 32'h4;
          cur_cnt_q[gnt_q] <= cur_cnt_q[gnt_q] - 16'h1;
        end
        if (cur_cnt_q[gnt_q] == 16'h1) ch_end_q[gnt_q] <= 1'b1;
      end
      // software write; dropped when it hits the served channel in the cycle its beat retires
      if (cfg_we && cfg_ch < 4'hA && !(beat_done && cfg_ch == gnt_q)) begin
        if (cfg_next) begin
          nxt_addr_q[cfg_ch] <= cfg_addr;
          nxt_cnt_q[cfg_ch] <= cfg_count;
        end else begin
          cur_addr_q[cfg_ch] <= cfg_addr;
          cur_cnt_q[cfg_ch] <= cfg_count;
        end
      end
    end
  end
  assign ch_end = ch_end_q;

  // acknowledge the served peripheral once per beat
  always_ff @(posedge clk_sys or negedge rst_core_n) begin
    if (!rst_core_n) ack_q <= 10'h0;
    else ack_q <= beat_done ? (10'h1 << gnt_q) : 10'h0;
  end
  assign ch_ack = ack_q;

  // ========================================================
  // transmit path through the two-entry buffer
  logic tx_push;
  assign tx_push = state_q == pdca_pkg::PDCA_READ && !rx_mask[gnt_q] && addr_ok(addr_q);
  pdca_buf2 u_buf (
    .clk_sys(clk_sys),
    .rst_n(rst_core_n),
    .in_valid(tx_push),
    .in_ready(buf_ready),
    .in_data(bus_rdata),
    .in_ch(gnt_q),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data(tx_data),
    .out_ch(tx_ch)
  );

  // ========================================================
  // checks
  sequence s_start_tx;
    state_q == pdca_pkg::PDCA_READ && !rx_mask[gnt_q];
  endsequence
  sequence s_start_rx;
    state_q == pdca_pkg::PDCA_READ && rx_mask[gnt_q];
  endsequence
  AST_TX_ONE_CYCLE: assert property (@(posedge clk_sys) disable iff (!rst_core_n)
    s_start_tx |=> state_q == pdca_pkg::PDCA_IDLE) else $error("tx beat not one cycle");
  AST_RX_TWO_CYCLE: assert property (@(posedge clk_sys) disable iff (!rst_core_n)
    s_start_rx |=> bus_write ##1 !bus_write) else $error("rx beat not two cycles");
  AST_PRIORITY: assert property (@(posedge clk_sys) disable iff (!rst_core_n)
    state_q == pdca_pkg::PDCA_IDLE && |eligible && buf_ready |=>
    gnt_q == pick_top($past(eligible))) else $error("wrong channel granted");
  AST_ONE_ACK: assert property (@(posedge clk_sys) disable iff (!rst_core_n)
    $onehot0(ch_ack)) else $error("more than one ack");
  AST_NO_FLASH: assert property (@(posedge clk_sys) disable iff (!rst_core_n)
    bus_req |-> addr_ok(bus_addr)) else $error("bus access outside map");
  AST_NO_DAC: assert property (@(posedge clk_sys) disable iff (!rst_core_n)
    !HAS_DAC |-> !ch_ack[`PDCA_CH_DAC_TX]) else $error("absent dac served");
  AST_ACK_AFTER: assert property (@(posedge clk_sys) disable iff (!rst_core_n)
    beat_done |=> ch_ack == (10'h1 << $past(gnt_q))) else $error("ack mismatch");
  AST_CHAIN: assert property (@(posedge clk_sys) disable iff (!rst_core_n)
    beat_done && cur_cnt_q[gnt_q] == 16'h1 && nxt_cnt_q[gnt_q] != 16'h0 &&
    !(cfg_we && cfg_ch == gnt_q) |=> ch_busy[$past(gnt_q)]) else $error("chain lost");
  // a transmit word is only fetched when the buffer has room for it
  AST_NO_LOST_WORD: assert property (@(posedge clk_sys) disable iff (!rst_core_n)
    tx_push |-> buf_ready) else $error("tx word pushed into full buffer");
endmodule : pdca_engine

//--- testbench/pdca_far_end.sv
`timescale 1ns/1ps
// ==========================================================
// far side: memory slave and a transmit sink that stalls
module pdca_far_end (
  // clock
  input wire logic clk_sys,
  // bus slave side
  input wire logic bus_req,
  input wire logic [31:0] bus_addr,
  output logic [31:0] bus_rdata,
  // transmit sink
  output logic tx_ready
);
  logic [31:0] junk_q; // filler negated every cycle outside beats; it starts at zero, so it stays zero
  // memory is a scramble of the address, so a wrong address shows
  assign bus_rdata = bus_req ? (bus_addr ^ 32'hC3A55A3C) : junk_q;
  initial begin
    junk_q = 32'h0;
    tx_ready = 1'b0;
  end
  // half the cycles stall, enough to fill the two-entry buffer
  always @(negedge clk_sys) begin
    junk_q <= ~junk_q + 32'h1;
    tx_ready <= $urandom_range(0, 1);
  end
endmodule : pdca_far_end

//--- testbench/testbench.sv
`timescale 1ns/1ps
`include "pdca_map.svh"
// ==========================================================
// bench: queue model of grants, addresses and transmit words
module testbench;
  logic clk_sys, rst_n, cfg_we, cfg_next, bus_req, bus_write, bus_err, tx_valid, tx_ready;
  logic [9:0] ch_req, ch_ack, ch_busy, ch_end;
  logic [319:0] ch_rx_data;
  logic [3:0] cfg_ch, tx_ch;
  logic [31:0] cfg_addr, bus_addr, bus_wdata, bus_rdata, tx_data;
  logic [15:0] cfg_count;
  logic [9:0] nd_ack, nd_busy; // copy without the dac channel
  int fail_count = 0, checked = 0, occ = 0; // occ: bus cycles of the open beat
  logic err_seen;
  logic [31:0] addr_seen;
  int grant_q[$]; // expected serving order
  logic [35:0] tx_q[$]; // expected {channel, word} stream
  logic [31:0] cur_a[10], nxt_a[10];
  int cnt[10], nxt_c[10];
  pdca_engine u_pdca_engine (.clk_sys(clk_sys), .rst_n(rst_n), .ch_req(ch_req),
    .ch_ack(ch_ack), .ch_rx_data(ch_rx_data), .cfg_we(cfg_we), .cfg_ch(cfg_ch),
    .cfg_next(cfg_next), .cfg_addr(cfg_addr), .cfg_count(cfg_count), .ch_busy(ch_busy),
    .ch_end(ch_end), .bus_req(bus_req), .bus_write(bus_write), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_err(bus_err),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_ch(tx_ch));
  pdca_far_end u_pdca_far_end (.clk_sys(clk_sys), .bus_req(bus_req),
    .bus_addr(bus_addr), .bus_rdata(bus_rdata), .tx_ready(tx_ready));
  // small-package copy fed the same stimulus; never stalls, so it drains first
  pdca_engine #(.HAS_DAC(1'b0)) u_pdca_engine_nodac (.clk_sys(clk_sys), .rst_n(rst_n),
    .ch_req(ch_req), .ch_ack(nd_ack), .ch_rx_data(ch_rx_data), .cfg_we(cfg_we),
    .cfg_ch(cfg_ch), .cfg_next(cfg_next), .cfg_addr(cfg_addr), .cfg_count(cfg_count),
    .ch_busy(nd_busy), .ch_end(), .bus_req(), .bus_write(), .bus_addr(), .bus_wdata(),
    .bus_rdata(bus_rdata), .bus_err(), .tx_valid(), .tx_ready(1'b1), .tx_data(), .tx_ch());
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic check(string what, logic [35:0] seen, logic [35:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  function automatic bit legal(logic [31:0] a);
    return ((a & `PDCA_SRAM_MASK) == `PDCA_SRAM_BASE) ||
      ((a & `PDCA_ROM_MASK) == `PDCA_ROM_BASE) || ((a & `PDCA_BRIDGE_MASK) == `PDCA_BRIDGE_BASE);
  endfunction : legal
  // ==========================================================
  // monitor: every retired beat is checked against the model
  always @(posedge clk_sys) begin : mon
    int ch;
    logic [31:0] a;
    if (bus_req || bus_err) begin
      occ++;
      addr_seen = bus_addr;
      err_seen = bus_err;
    end
    if (nd_ack[3])
      check("dac served", nd_ack, 10'h0);
    if (bus_write && grant_q.size() > 0)
      check("rx word", bus_wdata, ch_rx_data[grant_q[0]*32 +: 32]);
    if (ch_ack != 10'h0) begin
      ch = $clog2(ch_ack);
      check("one grant", $onehot(ch_ack), 1);
      check("grant", ch, grant_q.size() ? grant_q.pop_front() : 99);
      a = cur_a[ch];
      check("beat addr", addr_seen, a);
      check("bus error", err_seen, !legal(a));
      check("buffer end", ch_end, cnt[ch] == 1 ? ch_ack : 10'h0);
      if (legal(a)) begin
        check("occupancy", occ, ch >= `PDCA_FIRST_RX ? 2 : 1);
        if (ch < `PDCA_FIRST_RX) tx_q.push_back({ch[3:0], a ^ 32'hC3A55A3C});
      end
      occ = 0;
      cur_a[ch] = a + 32'h4;
      cnt[ch]--;
      // chaining: the queued buffer takes over with no software step
      if (cnt[ch] == 0 && nxt_c[ch] != 0) begin
        cur_a[ch] = nxt_a[ch];
        cnt[ch] = nxt_c[ch];
        nxt_c[ch] = 0;
      end
    end
    if (tx_valid && tx_ready)
      check("tx word", {tx_ch, tx_data}, tx_q.size() ? tx_q.pop_front() : 36'h0);
  end
  task automatic cfg(int ch, bit nx, logic [31:0] a, int c);
    @(negedge clk_sys);
    {cfg_we, cfg_ch, cfg_next, cfg_addr, cfg_count} = {1'b1, ch[3:0], nx, a, c[15:0]};
    @(negedge clk_sys);
    cfg_we = 1'b0;
    if (nx) {nxt_a[ch], nxt_c[ch]} = {a, c};
    else {cur_a[ch], cnt[ch]} = {a, c};
  endtask : cfg
  // raise requests together; highest index is served first
  task automatic run(string name, logic [9:0] req);
    int n;
    for (int ch = 9; ch >= 0; ch--)
      if (req[ch]) repeat (cnt[ch] + nxt_c[ch]) grant_q.push_back(ch);
    @(negedge clk_sys);
    for (int i = 0; i < 10; i++) ch_rx_data[i*32 +: 32] = $urandom;
    ch_req = req;
    n = 0;
    while ((grant_q.size() || tx_q.size()) && n < 3000) begin
      @(negedge clk_sys);
      n++;
    end
    check("drained", n < 3000, 1);
    check("idle", ch_busy & req, 0);
    ch_req = 10'h0;
    $display("test %s done", name);
  endtask : run
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  // watchdog far beyond the expected few hundred cycles
  initial begin
    #(50 * 40000);
    fail_count++;
    tally_and_finish();
  end
  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(32'hF2A62053));
    {rst_n, ch_req, ch_rx_data, cfg_we, cfg_ch, cfg_next, cfg_addr, cfg_count} = '0;
    for (int i = 0; i < 10; i++) {cnt[i], nxt_c[i]} = '0;
    repeat (5) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    cfg(0, 0, 32'h20000010, 2);
    cfg(0, 1, 32'h00800020, 1);
    run("chain", 10'h001);
    for (int ch = 0; ch < 10; ch++) cfg(ch, 0, 32'h40000000 + (ch << 8), 1);
    run("priority", 10'h3FF);
    check("dac absent", nd_busy, 10'h008);
    cfg(7, 0, 32'h00400000, 1);
    cfg(1, 0, 32'h10000000, 1);
    cfg(8, 0, 32'h20000100, 1);
    run("illegal", 10'h182);
    for (int k = 0; k < 4; k++) begin
      for (int ch = 0; ch < 10; ch++)
        cfg(ch, 0, 32'h20000000 + (ch << 12), $urandom_range(1, 4));
      run("random", $urandom_range(1, 1023));
    end
    tally_and_finish();
  end
endmodule : testbench
